// ==== design/rrld_consts.vh ====
// Constants for the retry reset and load diagnostics block.
// Assumes a 20 MHz clock and an AHB-Lite register port.
`ifndef RRLD_CONSTS_VH
`define RRLD_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RRLD_OFS_CFG0   8'h00
`define RRLD_OFS_CFG1   8'h04
`define RRLD_OFS_GEN    8'h08
`define RRLD_OFS_FLT0   8'h0c
`define RRLD_OFS_FLT1   8'h10
`define RRLD_OFS_STAT   8'h14
// ----------------------------------------
// Channel config fields
// ----------------------------------------
`define RRLD_B_RETRY    0
`define RRLD_B_UNLIM    1
`define RRLD_B_LIGHT    2
`define RRLD_B_FAST     3
`define RRLD_B_INTPWM   4
`define RRLD_B_DIRDIS   5
`define RRLD_B_OSDIS    6
`define RRLD_B_OFFDIS   7
`define RRLD_B_ONDIS    8
`define RRLD_CFG_RST    9'h000
// ----------------------------------------
// General config fields
// ----------------------------------------
`define RRLD_B_SNSA     0
`define RRLD_B_SNSB     1
`define RRLD_B_TH       2
`define RRLD_B_RATIO    3
`define RRLD_GEN_RST    4'h0
// ----------------------------------------
// Fault fields
// ----------------------------------------
`define RRLD_F_ON       0
`define RRLD_F_OFF      1
`define RRLD_F_OS       2
// ----------------------------------------
// Timing
// ----------------------------------------
`define RRLD_CLK_HZ     20000000
`define RRLD_OPEN_LOAD_ON_FAULT_MS    150
`define RRLD_OPEN_LOAD_ON_FAULT_CYC   ((`RRLD_CLK_HZ / 1000) * `RRLD_OPEN_LOAD_ON_FAULT_MS)
`endif

// ==== design/rrld_top.v ====
// Retry counter reset, load diagnostics and sense select for two channels.
// Assumes analog comparators arrive as asynchronous pins; AHB-Lite slave.
// Function
// [RULE_01] Clear retry counter on fail-safe entry, sleep exit, power-on reset.
// [RULE_02] Clear retry counter when unlimited-retry bit written to one.
// [RULE_03] Clear retry counter when retry select toggles to disable retry.
// [RULE_04] Counter cleared by unlimited retry delatches; restart after one period.
// [RULE_05] Lighting profile: reset overcurrent duration at every retry attempt.
// [RULE_06] Motor mode: reset duration at first clean period turn-off only; code pulses at every clean period turn-off.
// [RULE_07] Diagnostic faults set sticky bits, never switch channel off.
// [RULE_08] Each diagnostic suppressed by its own disable bit, bits 8..6.
// [RULE_09] Short-to-supply checked only while off; fault pin live.
// [RULE_10] Short-to-supply bit stays until fault register read.
// [RULE_11] Open-load-off checked every off period; pin live, bit sticky.
// [RULE_12] Open-load-on pulls pin low, sets bit, channel stays on.
// [RULE_13] High ratio: read clears open-load-on if off, or cause gone.
// [RULE_14] Low ratio internal fast: check at first turn-off after 150 ms.
// [RULE_15] Low ratio direct input: check each turn-off; bit 5 selects internal.
// [RULE_16] Low ratio: read clears only after clean completed check.
// [RULE_17] Two select bits choose channel 0, channel 1 or temperature.
// [RULE_18] Overcurrent window active: sensing disabled, sense-valid pin high; code gates the channel select only, temperature select stays.
// [RULE_19] Track-and-hold bit: 0 synchronous, 1 holds pre-turn-off current.
// [RULE_20] Ratio bit picks sense ratio; low ratio lowers thresholds.
// [RULE_21] Four-bit retry counter; after 15 set full, one last retry.
// [RULE_22] Auto-retry enabled when retry select equals load type input.
// [RULE_23] Read returns pre-clear value; events during read are kept.
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "rrld_consts.vh"

module rrld_top
#(
    parameter OPEN_LOAD_ON_FAULT_CYC = `RRLD_OPEN_LOAD_ON_FAULT_CYC
)
(
    input  wire        clk,
    input  wire        rst_b,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire        failsafe_enter,
    input  wire        sleep_exit,
    input  wire        por_event,
    input  wire [1:0]  load_type_input,
    input  wire [1:0]  chan_on,
    input  wire [1:0]  retry_attempt,
    input  wire [1:0]  retry_fault,
    input  wire [1:0]  oc_active,
    input  wire [1:0]  os_cmp,
    input  wire [1:0]  off_cmp,
    input  wire [1:0]  on_cmp,
    output wire [1:0]  latched_off,
    output wire [1:0]  retry_full,
    output wire [1:0]  dur_clear,
    output wire [1:0]  sense_chan,
    output wire        sense_temp,
    output wire        sense_hold,
    output wire        low_sense_ratio,
    output wire        fault_status_pin_n,
    output wire        sense_valid_pin_n
);
// ----------------------------------------
// Reset release and input synchronisers
// ----------------------------------------
reg  [1:0]  rst_sync_reg;
wire        rst_n = rst_sync_reg[1];
always @(posedge clk or negedge rst_b)
    if (!rst_b)
        rst_sync_reg <= 2'h0;
    else
        rst_sync_reg <= {rst_sync_reg[0], 1'b1};

// Analog flags are asynchronous: two flops before any logic
localparam NS = 19;
wire [NS-1:0] raw = {failsafe_enter, sleep_exit, por_event, load_type_input,
                     chan_on, retry_attempt, retry_fault, oc_active, os_cmp,
                     off_cmp, on_cmp};
reg  [NS-1:0] s1_reg;
reg  [NS-1:0] s2_reg;
always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
        s1_reg <= {NS{1'b0}};
        s2_reg <= {NS{1'b0}};
    end
    else
    begin
        s1_reg <= raw;
        s2_reg <= s1_reg;
    end
wire       fs_s   = s2_reg[18];
wire       slp_s  = s2_reg[17];
wire       por_s  = s2_reg[16];
wire [1:0] ltype  = s2_reg[15:14];
wire [1:0] on_s   = s2_reg[13:12];
wire [1:0] att_s  = s2_reg[11:10];
wire [1:0] flt_s  = s2_reg[9:8];
wire [1:0] oc_s   = s2_reg[7:6];
wire [1:0] os_s   = s2_reg[5:4];
wire [1:0] off_s  = s2_reg[3:2];
wire [1:0] onc_s  = s2_reg[1:0];
reg  [2:0] ev_reg;
always @(posedge clk or negedge rst_n)
    if (!rst_n)
        ev_reg <= 3'h0;
    else
        ev_reg <= {fs_s, slp_s, por_s};
wire glob_clr = (fs_s & ~ev_reg[2]) | (slp_s & ~ev_reg[1])
              | (por_s & ~ev_reg[0]);                          // [RULE_01]

// ----------------------------------------
// AHB-Lite slave
// ----------------------------------------
reg         ap_wr_reg;
reg         ap_rd_reg;
reg  [7:0]  ap_addr_reg;
reg  [31:0] rdata_reg;
wire        ap_go = hsel & hready & htrans[1];
always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
        ap_wr_reg   <= 1'b0;
        ap_rd_reg   <= 1'b0;
        ap_addr_reg <= 8'h00;
    end
    else
    begin
        ap_wr_reg   <= ap_go & hwrite;
        ap_rd_reg   <= ap_go & ~hwrite;
        ap_addr_reg <= haddr;
    end
assign hreadyout = 1'b1;
assign hresp     = 1'b0;
assign hrdata    = rdata_reg;

reg  [8:0]  cfg_reg [0:1];
reg  [3:0]  gen_reg;
reg  [2:0]  flt_reg [0:1];
wire        wr_cfg0 = ap_wr_reg & (ap_addr_reg == `RRLD_OFS_CFG0);
wire        wr_cfg1 = ap_wr_reg & (ap_addr_reg == `RRLD_OFS_CFG1);
wire        wr_gen  = ap_wr_reg & (ap_addr_reg == `RRLD_OFS_GEN);
wire        rd_f0   = ap_rd_reg & (ap_addr_reg == `RRLD_OFS_FLT0);
wire        rd_f1   = ap_rd_reg & (ap_addr_reg == `RRLD_OFS_FLT1);
wire [1:0]  wr_cfg  = {wr_cfg1, wr_cfg0};
wire [1:0]  rd_flt  = {rd_f1, rd_f0};

// Read data registered from pre-clear values
reg  [3:0]  cnt_reg [0:1];
reg  [1:0]  full_reg;
reg  [1:0]  latch_reg;
always @(posedge clk or negedge rst_n)
    if (!rst_n)
        rdata_reg <= 32'h0;
    else if (!(ap_go & ~hwrite))
        rdata_reg <= 32'h0;
    else if (haddr == `RRLD_OFS_CFG0)
        rdata_reg <= {23'h0, cfg_reg[0]};
    else if (haddr == `RRLD_OFS_CFG1)
        rdata_reg <= {23'h0, cfg_reg[1]};
    else if (haddr == `RRLD_OFS_GEN)
        rdata_reg <= {28'h0, gen_reg};
    else if (haddr == `RRLD_OFS_FLT0)
        rdata_reg <= {29'h0, flt_reg[0]};                      // [RULE_23]
    else if (haddr == `RRLD_OFS_FLT1)
        rdata_reg <= {29'h0, flt_reg[1]};
    else if (haddr == `RRLD_OFS_STAT)
        rdata_reg <= {16'h0, cnt_reg[1], cnt_reg[0], latch_reg,
                      full_reg, 4'h0};
    else
        rdata_reg <= 32'h0;

always @(posedge clk or negedge rst_n)
    if (!rst_n)
        gen_reg <= `RRLD_GEN_RST;
    else if (wr_gen)
        gen_reg <= hwdata[3:0];

// ----------------------------------------
// Sense selection
// ----------------------------------------
wire any_oc = |oc_s;
reg  [1:0]  schan_reg;
reg         stemp_reg;
reg         shold_reg;
reg         sratio_reg;
reg         svalid_n_reg;
always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
        schan_reg    <= 2'h0;
        stemp_reg    <= 1'b0;
        shold_reg    <= 1'b0;
        sratio_reg   <= 1'b0;
        svalid_n_reg <= 1'b1;
    end
    else
    begin
        // 01 ch0, 10 ch1, 11 temperature; current off in OC window
        schan_reg[0] <= ~any_oc & (gen_reg[1:0] == 2'h1);      // [RULE_17] [RULE_18]
        schan_reg[1] <= ~any_oc & (gen_reg[1:0] == 2'h2);      // [RULE_17] [RULE_18]
        stemp_reg    <= (gen_reg[1:0] == 2'h3);                // [RULE_17]
        shold_reg    <= gen_reg[`RRLD_B_TH];                   // [RULE_19]
        sratio_reg   <= gen_reg[`RRLD_B_RATIO];                // [RULE_20]
        // Valid only while a selected channel conducts outside OC
        svalid_n_reg <= any_oc | ~(|(schan_reg & on_s));       // [RULE_18] [RULE_19]
    end
assign sense_chan      = schan_reg;
assign sense_temp      = stemp_reg;
assign sense_hold      = shold_reg;
assign low_sense_ratio = sratio_reg;                           // [RULE_20]
assign sense_valid_pin_n = svalid_n_reg;

// ----------------------------------------
// Per-channel retry and diagnostics
// ----------------------------------------
reg  [1:0]  on_d_reg;
reg  [1:0]  att_d_reg;
reg  [1:0]  dclr_reg;
reg  [1:0]  ocseen_reg;
reg  [1:0]  live_reg;
reg  [1:0]  okchk_reg;
reg  [31:0] tmr_reg [0:1];
reg  [1:0]  restart_reg;
wire [1:0]  live_next;
genvar g;
generate
for (g = 0; g < 2; g = g + 1)
begin : ch
    wire [8:0] c      = cfg_reg[g];
    wire [8:0] nc     = hwdata[8:0];
    wire       toff   = on_d_reg[g] & ~on_s[g];
    wire       att    = att_s[g] & ~att_d_reg[g];
    wire       en_now = (c[`RRLD_B_RETRY] == ltype[g]);        // [RULE_22]
    wire       unl_set = wr_cfg[g] & nc[`RRLD_B_UNLIM];        // [RULE_02]
    wire       dis_tog = wr_cfg[g] & en_now
                       & (nc[`RRLD_B_RETRY] != ltype[g]);      // [RULE_03]
    wire       cnt_clr = glob_clr | unl_set | dis_tog;
    wire       lowr   = gen_reg[`RRLD_B_RATIO];
    wire       tmo    = (tmr_reg[g] >= OPEN_LOAD_ON_FAULT_CYC - 1);
    wire       intctl = c[`RRLD_B_INTPWM] | c[`RRLD_B_DIRDIS]; // [RULE_15]
    wire       chk    = lowr & c[`RRLD_B_FAST] & toff
                      & (intctl ? tmo : 1'b1);                 // [RULE_14] [RULE_15]
    // Set sources, gated by disables; never touch channel state
    wire       set_os  = ~c[`RRLD_B_OSDIS] & ~on_s[g] & os_s[g];   // [RULE_07] [RULE_08] [RULE_09]
    wire       set_off = ~c[`RRLD_B_OFFDIS] & ~on_s[g] & off_s[g]; // [RULE_08] [RULE_11]
    wire       on_hi   = ~c[`RRLD_B_ONDIS] & ~lowr & on_s[g] & onc_s[g];
    wire       on_lo   = ~c[`RRLD_B_ONDIS] & chk & onc_s[g];
    wire       set_on  = on_hi | on_lo;                        // [RULE_12]
    // Read clear conditions; set wins over clear
    wire       clr_on  = rd_flt[g] & (lowr ? okchk_reg[g]      // [RULE_16]
                       : (~on_s[g] | ~onc_s[g]));              // [RULE_13]
    wire [2:0] f      = flt_reg[g];
    assign live_next[g] = set_os | set_off | set_on
                        | (on_hi);                             // [RULE_09] [RULE_11] [RULE_12]
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            cfg_reg[g]    <= `RRLD_CFG_RST;
            flt_reg[g]    <= 3'h0;
            cnt_reg[g]    <= 4'h0;
            tmr_reg[g]    <= 32'h0;
            on_d_reg[g]   <= 1'b0;
            att_d_reg[g]  <= 1'b0;
            dclr_reg[g]   <= 1'b0;
            ocseen_reg[g] <= 1'b0;
            okchk_reg[g]  <= 1'b0;
            full_reg[g]   <= 1'b0;
            latch_reg[g]  <= 1'b0;
            restart_reg[g] <= 1'b0;
        end
        else
        begin
            on_d_reg[g]  <= on_s[g];
            att_d_reg[g] <= att_s[g];
            if (wr_cfg[g])
                cfg_reg[g] <= nc;
            flt_reg[g][`RRLD_F_OS]  <= set_os
                | (f[`RRLD_F_OS] & ~rd_flt[g]);                // [RULE_10] [RULE_23]
            flt_reg[g][`RRLD_F_OFF] <= set_off
                | (f[`RRLD_F_OFF] & ~rd_flt[g]);               // [RULE_11] [RULE_23]
            flt_reg[g][`RRLD_F_ON]  <= set_on
                | (f[`RRLD_F_ON] & ~clr_on);                   // [RULE_12] [RULE_23]
            if (chk)
                okchk_reg[g] <= ~onc_s[g];
            else if (rd_flt[g])
                okchk_reg[g] <= 1'b0;
            if (chk | ~lowr)
                tmr_reg[g] <= 32'h0;                           // [RULE_14]
            else if (!tmo)
                tmr_reg[g] <= tmr_reg[g] + 32'h1;
            // Retry counter and latching
            if (cnt_clr)
            begin
                cnt_reg[g]  <= 4'h0;                           // [RULE_01] [RULE_02] [RULE_03]
                full_reg[g] <= 1'b0;
                if (unl_set & latch_reg[g])
                begin
                    latch_reg[g]   <= 1'b0;                    // [RULE_04]
                    restart_reg[g] <= en_now;                  // [RULE_04]
                end
            end
            else if (att & en_now & ~c[`RRLD_B_UNLIM])
            begin
                restart_reg[g] <= 1'b0;
                if (full_reg[g] & flt_s[g])
                    latch_reg[g] <= 1'b1;                      // [RULE_21]
                else if (cnt_reg[g] == 4'hf)
                    full_reg[g] <= 1'b1;                       // [RULE_21]
                else
                begin
                    cnt_reg[g] <= cnt_reg[g] + 4'h1;
                    if (cnt_reg[g] == 4'he)
                        full_reg[g] <= 1'b1;                   // [RULE_21]
                end
            end
            else if (att)
                restart_reg[g] <= 1'b0;
            // Duration counter reset policy
            if (oc_s[g])
                ocseen_reg[g] <= 1'b1;
            else if (toff)
                ocseen_reg[g] <= 1'b0;
            dclr_reg[g] <= c[`RRLD_B_LIGHT] ? att                // [RULE_05]
                         : (toff & ~ocseen_reg[g] & ~oc_s[g]); // [RULE_06]
        end
end
endgenerate

// ----------------------------------------
// Fault pin, live indication
// ----------------------------------------
always @(posedge clk or negedge rst_n)
    if (!rst_n)
        live_reg <= 2'h0;
    else
        live_reg <= live_next;                                 // [RULE_09]
assign fault_status_pin_n = ~(|live_reg);
assign latched_off = latch_reg;
assign retry_full  = full_reg;
assign dur_clear   = dclr_reg;

endmodule // rrld_top

// ==== verif/rrld_props.sv ====
// Checker: port relations of rrld_top.
// Assumes bind into rrld_top; sees its ports only.
`timescale 1ns/100ps
module rrld_props
(
    input wire        clk,
    input wire        rst_b,
    input wire        hsel,
    input wire        hready,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        failsafe_enter,
    input wire        sleep_exit,
    input wire        por_event,
    input wire [1:0]  retry_fault,
    input wire [1:0]  oc_active,
    input wire [1:0]  os_cmp,
    input wire [1:0]  off_cmp,
    input wire [1:0]  on_cmp,
    input wire [1:0]  latched_off,
    input wire [1:0]  retry_full,
    input wire [1:0]  dur_clear,
    input wire [1:0]  sense_chan,
    input wire        sense_temp,
    input wire        fault_status_pin_n,
    input wire        sense_valid_pin_n
);
// ----
// Assertions
// ----
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
chk_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
chk_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
chk_rdata_idle: assert property
    (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
    else $error("hrdata outside data phase");
chk_sense_onehot: assert property ($onehot0({sense_temp, sense_chan}))
    else $error("two sense sources");
chk_sync_oc: assert property ((|oc_active) [*5] |-> sense_valid_pin_n)
    else $error("sense valid during overcurrent");
chk_dur_pulse: assert property
    (|dur_clear |=> (dur_clear & $past(dur_clear)) == 2'h0)
    else $error("duration clear longer than a cycle");
chk_retry_clear: assert property
    ($rose(failsafe_enter || sleep_exit || por_event)
        |-> ##[1:6] retry_full == 2'h0)
    else $error("retry full kept after clear event");
// Pin reflects diagnostics only; checked only while retry faults and latches are quiet too
chk_pin_idle: assert property
    ((!(|{os_cmp, off_cmp, on_cmp, retry_fault, latched_off})) [*5]
        |-> fault_status_pin_n)
    else $error("fault pin low without cause");
endmodule // rrld_props
bind rrld_top rrld_props i_rrld_props
(
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .hready(hready),
    .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .failsafe_enter(failsafe_enter), .sleep_exit(sleep_exit),
    .por_event(por_event), .retry_fault(retry_fault),
    .oc_active(oc_active), .os_cmp(os_cmp), .off_cmp(off_cmp),
    .on_cmp(on_cmp), .latched_off(latched_off),
    .retry_full(retry_full), .dur_clear(dur_clear),
    .sense_chan(sense_chan), .sense_temp(sense_temp),
    .fault_status_pin_n(fault_status_pin_n),
    .sense_valid_pin_n(sense_valid_pin_n)
);

// ==== verif/rrld_host.sv ====
// Host model: AHB-Lite master, single word transfers.
// Assumes hready is the one slave's hreadyout.
`timescale 1ns/100ps
module rrld_host
(
    input  wire        clk,
    input  wire        hready,
    input  wire [31:0] hrdata,
    output reg         hsel = 1'b0,
    output reg  [7:0]  haddr = 8'h00,
    output reg  [1:0]  htrans = 2'h0,
    output reg         hwrite = 1'b0,
    output reg  [2:0]  hsize = 3'h2,
    output reg  [31:0] hwdata = 32'h0
);
// Stale write data is inverted so it never passes for fresh
task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] r);
begin
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hwdata <= ~hwdata;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
end
endtask
endmodule // rrld_host

// ==== verif/rrld_tb_top.sv ====
// Bench: drives rrld_top through the host model, checks outputs.
// Assumes comparator and event pins are plain levels.
`timescale 1ns/100ps
`include "rrld_consts.vh"
module rrld_tb_top;
reg         clk = 1'b0;
reg         rst_b = 1'b0;
reg  [2:0]  ev = 3'h0;
reg  [2:0]  cmp = 3'h0;
reg  [1:0]  lt = 2'h0, on = 2'h0, att = 2'h0, rf = 2'h0, oc = 2'h0;
wire [31:0] hrdata, hwdata;
wire [7:0]  haddr;
wire [2:0]  hsize;
wire [1:0]  htrans, latched_off, retry_full, dur_clear, sense_chan;
wire        hsel, hwrite, hreadyout, hresp, sense_temp, sense_hold;
wire        low_sense_ratio, fault_status_pin_n, sense_valid_pin_n;
integer     n_errors = 0, check_count = 0, seed = 35535, n_dur = 0;
integer     i, k, d;
reg  [31:0] r, v;
always #25 clk = ~clk;
always @(posedge clk) if (dur_clear[0] === 1'b1) n_dur = n_dur + 1;
rrld_host i_rrld_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));
rrld_top #(.OPEN_LOAD_ON_FAULT_CYC(20)) i_rrld_top (.clk(clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .failsafe_enter(ev[0]),
    .sleep_exit(ev[1]), .por_event(ev[2]), .load_type_input(lt),
    .chan_on(on), .retry_attempt(att), .retry_fault(rf), .oc_active(oc),
    .os_cmp({1'b0, cmp[2]}), .off_cmp({1'b0, cmp[1]}),
    .on_cmp({1'b0, cmp[0]}), .latched_off(latched_off),
    .retry_full(retry_full), .dur_clear(dur_clear),
    .sense_chan(sense_chan), .sense_temp(sense_temp),
    .sense_hold(sense_hold), .low_sense_ratio(low_sense_ratio),
    .fault_status_pin_n(fault_status_pin_n),
    .sense_valid_pin_n(sense_valid_pin_n));
// ----
// Tasks
// ----
task cyc(input integer n); repeat (n) @(posedge clk); endtask
task chk(input [8*6:1] nm, input [31:0] e, input [31:0] g);
begin
    check_count = check_count + 1;
    if (g !== e)
    begin
        n_errors = n_errors + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, g);
    end
end
endtask
task wr(input [7:0] a, input [31:0] dd); i_rrld_host.xfer(1'b1, a, dd, r);
endtask
task rd(input [7:0] a, input [31:0] e);
begin
    i_rrld_host.xfer(1'b0, a, 32'h0, r);
    chk("rdata", e, r);
end
endtask
task pulse;
begin
    att[0] <= 1'b1;
    cyc(3);
    att[0] <= 1'b0;
    cyc(3);
end
endtask
task test_done;
begin
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
end
endtask
initial
begin
    #(20000 * 50);
    n_errors = n_errors + 1;
    test_done;
end
// ----
// Scenarios
// ----
initial
begin
    cyc(20);
    rst_b <= 1'b1;
    cyc(4);
    rd(`RRLD_OFS_STAT, 32'h0);
    wr(8'h18, 32'hffff);
    rd(8'h18, 32'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
        v = {$random(seed)} % 4 * 4 + i;
        wr(`RRLD_OFS_GEN, v);
        rd(`RRLD_OFS_GEN, v);
        chk("chan", (i == 1) ? 1 : (i == 2) ? 2 : 0, sense_chan);
        chk("temp", i == 3, sense_temp);
        chk("hold", v[2], sense_hold);
        chk("ratio", v[3], low_sense_ratio);
    end
    wr(`RRLD_OFS_GEN, 32'h1);
    on[0] <= 1'b1;
    cyc(6);
    chk("sync", 0, sense_valid_pin_n);
    oc <= 2'h2;
    cyc(6);
    chk("sync", 1, sense_valid_pin_n);
    on <= 2'h0;
    oc <= 2'h0;
    wr(`RRLD_OFS_GEN, 32'h0);
    $display("test sense done");
    for (d = 0; d < 3; d = d + 1)
        for (k = 0; k < 2; k = k + 1)
        begin
            wr(`RRLD_OFS_CFG0, k << (8 - d));
            on <= {1'b0, d == 0};
            cmp[d] <= 1'b1;
            cyc(6);
            chk("pin", k, fault_status_pin_n);
            chk("latch", 0, latched_off);
            cmp[d] <= 1'b0;
            cyc(6);
            chk("pin", 1, fault_status_pin_n);
            rd(`RRLD_OFS_FLT0, (1 - k) << d);
            rd(`RRLD_OFS_FLT0, 0);
        end
    on <= 2'h0;
    wr(`RRLD_OFS_GEN, 32'h8);
    wr(`RRLD_OFS_CFG0, 32'h8);
    cmp[0] <= 1'b1;
    for (i = 0; i < 2; i = i + 1)
    begin
        on[0] <= 1'b1;
        cyc(6);
        on[0] <= 1'b0;
        cyc(6);
        cmp[0] <= 1'b0;
        rd(`RRLD_OFS_FLT0, 1);
    end
    rd(`RRLD_OFS_FLT0, 0);
    $display("test diagnostics done");
    wr(`RRLD_OFS_GEN, 32'h0);
    wr(`RRLD_OFS_CFG0, 32'h4);
    rf <= 2'h1;
    n_dur = 0;
    for (i = 0; i < 15; i = i + 1)
        pulse;
    chk("dur", 15, n_dur);
    rd(`RRLD_OFS_STAT, 32'h0f10);
    pulse;
    pulse;
    chk("latch", 1, latched_off);
    wr(`RRLD_OFS_CFG0, 32'h6);
    cyc(2);
    chk("latch", 0, latched_off);
    rd(`RRLD_OFS_STAT, 32'h0);
    for (k = 0; k < 5; k = k + 1)
    begin
        lt <= {1'b0, k == 4};
        wr(`RRLD_OFS_CFG0, 32'h4 | (k == 4));
        rf <= 2'h1;
        pulse;
        pulse;
        rd(`RRLD_OFS_STAT, 32'h200);
        rf <= 2'h0;
        if (k < 3)
            ev[k] <= 1'b1;
        else
            wr(`RRLD_OFS_CFG0, 32'h5 - (k == 4));
        cyc(6);
        ev <= 3'h0;
        rd(`RRLD_OFS_STAT, 32'h0);
    end
    wr(`RRLD_OFS_CFG0, 32'h0);
    n_dur = 0;
    oc[0] <= 1'b1;
    on[0] <= 1'b1;
    cyc(6);
    oc[0] <= 1'b0;
    cyc(6);
    on[0] <= 1'b0;
    cyc(6);
    chk("dur", 0, n_dur);
    on[0] <= 1'b1;
    cyc(6);
    on[0] <= 1'b0;
    cyc(6);
    chk("dur", 1, n_dur);
    $display("test retry done");
    test_done;
end
endmodule // rrld_tb_top
